// ===== hw/mci_pkg.sv
package mci_pkg;
   // =========================================================
   // error codes
   localparam logic [11:0] ERR_NONE = 12'h000;
   localparam logic [11:0] ERR_DRV_HALT = 12'h206;
   localparam logic [11:0] ERR_SERVO_OFF = 12'h20A;
   localparam logic [11:0] ERR_DUP_START = 12'h20C;
   localparam logic [11:0] ERR_PAUSE = 12'h20D;
   localparam logic [11:0] ERR_SOFT_LIMIT = 12'h20E;
   localparam logic [11:0] ERR_HOME_MOVING = 12'h210;
   localparam logic [11:0] ERR_JOG_MOVING = 12'h211;
   localparam logic [11:0] ERR_CUTOFF = 12'h212;
   localparam logic [11:0] ERR_SUCTION = 12'h213;
   localparam logic [11:0] ERR_WR_AUTO = 12'h220;
   localparam logic [11:0] ERR_WR_MON = 12'h221;
   // =========================================================
   // register map
   localparam logic [3:0] ADDR_ERR_CODE = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;
   localparam logic [3:0] ADDR_STATE = 4'h3;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [1:0] IRQ_BIT_ERROR = 2'h0;
   localparam logic [1:0] IRQ_BIT_CUTOFF = 2'h1;
   localparam logic [1:0] IRQ_BIT_DONE = 2'h2;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;
   localparam logic [11:0] RST_ERR_CODE = 12'h000;
   // =========================================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int CUTOFF_SETTLE_NS = 50;
   localparam int CUTOFF_SETTLE_CYC = (CUTOFF_SETTLE_NS * CLK_MHZ + 999) / 1000;
   // =========================================================
   // types
   typedef enum logic [3:0] {
      MV_IDLE = 4'b0001,
      MV_RUN = 4'b0010,
      MV_STOP = 4'b0100,
      MV_CUT = 4'b1000
   } mci_move_type;
   typedef enum logic [2:0] {
      SU_STANDBY = 3'b001,
      SU_SUCTION = 3'b010,
      SU_RELEASE = 3'b100
   } mci_suck_type;
   typedef enum logic [1:0] {
      MODE_TEACH = 2'h0,
      MODE_AUTO = 2'h1,
      MODE_MONITOR = 2'h2
   } mci_mode_type;
   typedef struct packed {
      logic servo_enable_input;
      logic move_start_input;
      logic pause_hold_n;
      logic home_input;
      logic jog_input;
      logic driver_halt_input;
   } mci_plc_type;
   typedef struct packed {
      logic motor_low;
      logic stop_latched;
      logic estop_24v_ok;
      logic gateway_alarm;
      logic actuator_comm_err;
      logic soft_limit;
   } mci_cut_type;
   typedef struct packed {
      logic enable_mid;
      logic write_req;
      logic suction_req;
      logic release_req;
      logic move_req;
   } mci_pend_type;
endpackage

// ===== hw/mci_edge.sv
`timescale 1ns/1ps
module mci_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [5:0] level,
   output logic [5:0] rise,
   output logic [5:0] fall
);
   logic [5:0] prev_q;
   // =========================================================
   // edge detection of plc levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 6'h00;
      end else begin
         prev_q <= level;
      end
   end
   assign rise = level & ~prev_q;
   assign fall = ~level & prev_q;
endmodule

// ===== hw/mci_cutoff.sv
`timescale 1ns/1ps
module mci_cutoff (
   input wire logic clk,
   input wire logic rst_n,
   input wire mci_pkg::mci_cut_type cut_in,
   output logic cutoff,
   output logic cutoff_rise
);
   logic raw_cut;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic cut_q;
   logic cut_d;
   // =========================================================
   // cutoff qualification
   // short filter so a glitch on the stop lines does not flicker the state
   assign raw_cut = cut_in.motor_low | cut_in.stop_latched | ~cut_in.estop_24v_ok
      | cut_in.gateway_alarm | cut_in.actuator_comm_err;
   assign cnt_d = raw_cut ? 4'h0
      : (cnt_q == 4'(mci_pkg::CUTOFF_SETTLE_CYC)) ? cnt_q : cnt_q + 4'h1;
   // entry is immediate; leaving waits out the settle count of quiet cycles
   assign cut_d = raw_cut | (cut_q & (cnt_q != 4'(mci_pkg::CUTOFF_SETTLE_CYC)));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         cut_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         cut_q <= cut_d;
      end
   end
   assign cutoff = cut_q;
   assign cutoff_rise = raw_cut & ~cut_q;
endmodule

// ===== hw/mci_top.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - driver halt input stops driving and raises code 206.
// - movement command while servo off is refused with code 20A.
// - servo enable dropping during movement stops servo, abandons move, code 20A.
// - start asserted during movement is a duplicate, code 20C.
// - pause line going inactive during movement stops it, code 20D.
// - reaching a software limit raises code 20E.
// - home input during movement raises code 210.
// - jog input during movement raises code 211.
// - motor power at or below 16.8V means cutoff, commands refused, code 212.
// - pendant stop latched or missing emergency +24V means cutoff, code 212.
// - gateway alarm means cutoff, commands answered with code 212.
// - actuator communication error means cutoff, commands answered with 212.
// - pendant operation accepted only with enabling switch held mid.
// - suction accepted only in standby, else code 213.
// - release accepted only while suctioning, else code 213.
// - position or parameter writes in automatic mode rejected, code 220.
// - writes in monitor mode rejected with code 221, not applied.
module mci_top (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire mci_pkg::mci_plc_type PLC_IN,
   input wire mci_pkg::mci_cut_type CUT_IN,
   input wire mci_pkg::mci_pend_type PEND_IN,
   input wire logic MOVE_DONE,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic SERVO_ON,
   output logic DRIVE_EN,
   output logic MOVING,
   output logic WRITE_APPLY,
   output logic SUCTION_ON,
   output logic [11:0] ERR_CODE,
   output logic ERR_EVENT,
   output logic IRQ
);
   mci_pkg::mci_move_type mv_q;
   mci_pkg::mci_move_type mv_d;
   mci_pkg::mci_suck_type su_q;
   mci_pkg::mci_suck_type su_d;
   mci_pkg::mci_mode_type mode_q;
   logic [5:0] rise;
   logic [5:0] fall;
   logic cutoff;
   logic cutoff_rise;
   logic [11:0] err_q;
   logic [11:0] err_d;
   logic evt_q;
   logic raise;
   logic [11:0] raise_code;
   logic [2:0] irq_st_q;
   logic [2:0] irq_st_d;
   logic [2:0] irq_mask_q;
   logic [2:0] irq_set;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic wapply_q;
   logic servo_q;
   logic moving;
   logic pend_ok;
   logic start_ev;
   logic move_cmd;
   logic wr_ctl;
   logic wr_st;
   logic wr_mask;
   logic halt;
   logic limit_rise;
   logic limit_q;

   // =========================================================
   // helper functions
   function automatic logic [11:0] pick(input logic c, input logic [11:0] a,
                                        input logic [11:0] b);
      pick = c ? a : b;
   endfunction

   // =========================================================
   // input conditioning
   mci_edge u_edge (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .level(PLC_IN),
      .rise(rise),
      .fall(fall)
   );
   mci_cutoff u_cut (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .cut_in(CUT_IN),
      .cutoff(cutoff),
      .cutoff_rise(cutoff_rise)
   );

   // struct bit order: servo=5 start=4 pause=3 home=2 jog=1 halt=0
   assign moving = (mv_q == mci_pkg::MV_RUN);
   assign halt = PLC_IN.driver_halt_input;
   assign pend_ok = PEND_IN.enable_mid;
   assign start_ev = rise[4];
   assign move_cmd = start_ev | (PEND_IN.move_req & pend_ok);

   // =========================================================
   // register decode
   assign wr_ctl = REG_WR & (REG_ADDR == mci_pkg::ADDR_CONTROL);
   assign wr_st = REG_WR & (REG_ADDR == mci_pkg::ADDR_IRQ_STATUS);
   assign wr_mask = REG_WR & (REG_ADDR == mci_pkg::ADDR_IRQ_MASK);

   // =========================================================
   // error selection, highest priority first
   // cutoff outranks everything but driver halt since no command can be honoured then
   always_comb begin
      raise = 1'b1;
      raise_code = mci_pkg::ERR_NONE;
      if (halt && (rise[0] || move_cmd)) begin
         raise_code = mci_pkg::ERR_DRV_HALT;
      end else if (cutoff_rise || (cutoff && (move_cmd
                   || (PEND_IN.suction_req && pend_ok)
                   || (PEND_IN.release_req && pend_ok)
                   || (PEND_IN.write_req && pend_ok))))  begin
         raise_code = mci_pkg::ERR_CUTOFF;
      end else if (moving && fall[5]) begin
         raise_code = mci_pkg::ERR_SERVO_OFF;
      end else if (move_cmd && !PLC_IN.servo_enable_input) begin
         raise_code = mci_pkg::ERR_SERVO_OFF;
      end else if (moving && fall[3]) begin
         raise_code = mci_pkg::ERR_PAUSE;
      end else if (moving && start_ev) begin
         raise_code = mci_pkg::ERR_DUP_START;
      end else if (moving && rise[2]) begin
         raise_code = mci_pkg::ERR_HOME_MOVING;
      end else if (moving && rise[1]) begin
         raise_code = mci_pkg::ERR_JOG_MOVING;
      end else if (limit_rise) begin
         raise_code = mci_pkg::ERR_SOFT_LIMIT;
      end else if (PEND_IN.suction_req && pend_ok && su_q != mci_pkg::SU_STANDBY) begin
         raise_code = mci_pkg::ERR_SUCTION;
      end else if (PEND_IN.release_req && pend_ok && su_q != mci_pkg::SU_SUCTION) begin
         raise_code = mci_pkg::ERR_SUCTION;
      end else if (PEND_IN.write_req && pend_ok) begin
         raise_code = pick(mode_q == mci_pkg::MODE_MONITOR,
                           mci_pkg::ERR_WR_MON,
                           pick(mode_q == mci_pkg::MODE_AUTO,
                                mci_pkg::ERR_WR_AUTO, mci_pkg::ERR_NONE));
         raise = (mode_q != mci_pkg::MODE_TEACH);
      end else begin
         raise = 1'b0;
      end
   end

   assign limit_rise = CUT_IN.soft_limit & ~limit_q;

   // =========================================================
   // movement state machine
   always_comb begin
      mv_d = mv_q;
      case (mv_q)
         mci_pkg::MV_IDLE: begin
            if (cutoff || halt) begin
               mv_d = mci_pkg::MV_CUT;
            end else if (move_cmd && PLC_IN.servo_enable_input && PLC_IN.pause_hold_n
                         && !CUT_IN.soft_limit) begin
               mv_d = mci_pkg::MV_RUN;
            end
         end
         mci_pkg::MV_RUN: begin
            if (cutoff || halt) begin
               mv_d = mci_pkg::MV_CUT;
            end else if (fall[5] || fall[3] || CUT_IN.soft_limit) begin
               mv_d = mci_pkg::MV_STOP;
            end else if (MOVE_DONE) begin
               mv_d = mci_pkg::MV_IDLE;
            end
         end
         mci_pkg::MV_STOP: begin
            mv_d = mci_pkg::MV_IDLE;
         end
         mci_pkg::MV_CUT: begin
            if (!cutoff && !halt) begin
               mv_d = mci_pkg::MV_IDLE;
            end
         end
         default: begin
            mv_d = mci_pkg::MV_IDLE;
         end
      endcase
   end

   // =========================================================
   // suction status
   always_comb begin
      su_d = su_q;
      case (su_q)
         mci_pkg::SU_STANDBY: begin
            if (PEND_IN.suction_req && pend_ok && !cutoff) begin
               su_d = mci_pkg::SU_SUCTION;
            end
         end
         mci_pkg::SU_SUCTION: begin
            if (PEND_IN.release_req && pend_ok && !cutoff) begin
               su_d = mci_pkg::SU_RELEASE;
            end
         end
         mci_pkg::SU_RELEASE: begin
            su_d = mci_pkg::SU_STANDBY;
         end
         default: begin
            su_d = mci_pkg::SU_STANDBY;
         end
      endcase
   end

   // =========================================================
   // error record and interrupt status
   assign err_d = raise ? raise_code : err_q;
   assign irq_set = {MOVE_DONE & moving, cutoff_rise, raise};
   // set wins over a same-cycle write-one clear
   assign irq_st_d = (irq_st_q & ~(wr_st ? REG_WDATA[2:0] : 3'h0)) | irq_set;

   always_comb begin
      case (REG_ADDR)
         mci_pkg::ADDR_ERR_CODE: rdata_d = {20'h00000, err_q};
         mci_pkg::ADDR_IRQ_STATUS: rdata_d = {29'h00000000, irq_st_q};
         mci_pkg::ADDR_IRQ_MASK: rdata_d = {29'h00000000, irq_mask_q};
         mci_pkg::ADDR_STATE: rdata_d = {21'h000000, su_q, mv_q, cutoff, servo_q, mode_q};
         mci_pkg::ADDR_CONTROL: rdata_d = {30'h00000000, mode_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   // =========================================================
   // registers
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mv_q <= mci_pkg::MV_IDLE;
         su_q <= mci_pkg::SU_STANDBY;
         mode_q <= mci_pkg::MODE_TEACH;
         err_q <= mci_pkg::RST_ERR_CODE;
         evt_q <= 1'b0;
         irq_st_q <= 3'h0;
         irq_mask_q <= mci_pkg::RST_IRQ_MASK;
         rdata_q <= 32'h00000000;
         wapply_q <= 1'b0;
         servo_q <= 1'b0;
         limit_q <= 1'b0;
      end else begin
         mv_q <= mv_d;
         su_q <= su_d;
         err_q <= err_d;
         evt_q <= raise;
         irq_st_q <= irq_st_d;
         limit_q <= CUT_IN.soft_limit;
         rdata_q <= REG_RD ? rdata_d : 32'h00000000;
         // only teach mode lets a pendant write through
         wapply_q <= PEND_IN.write_req & pend_ok & ~cutoff
            & (mode_q == mci_pkg::MODE_TEACH);
         servo_q <= PLC_IN.servo_enable_input & ~cutoff & ~halt;
         if (wr_mask) begin
            irq_mask_q <= REG_WDATA[2:0];
         end
         if (wr_ctl && REG_WDATA[1:0] != 2'h3) begin
            mode_q <= mci_pkg::mci_mode_type'(REG_WDATA[1:0]);
         end
      end
   end

   // =========================================================
   // outputs
   assign REG_RDATA = rdata_q;
   assign SERVO_ON = servo_q;
   assign DRIVE_EN = servo_q & ~cutoff & ~halt;
   assign MOVING = moving;
   assign WRITE_APPLY = wapply_q;
   assign SUCTION_ON = (su_q == mci_pkg::SU_SUCTION);
   assign ERR_CODE = err_q;
   assign ERR_EVENT = evt_q;
   assign IRQ = |(irq_st_q & irq_mask_q);
endmodule

// ===== bench/mci_top_checker.sv
`timescale 1ns/1ps
// =========================================================
// port-level checks on the interlock
module mci_top_checker (
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire mci_pkg::mci_plc_type PLC_IN,
   input wire mci_pkg::mci_cut_type CUT_IN,
   input wire mci_pkg::mci_pend_type PEND_IN,
   input wire logic MOVE_DONE,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic DRIVE_EN,
   input wire logic MOVING,
   input wire logic WRITE_APPLY,
   input wire logic SUCTION_ON,
   input wire logic [11:0] ERR_CODE,
   input wire logic ERR_EVENT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   wire halt = PLC_IN.driver_halt_input;
   // missing +24V counts as a cause, hence the inversion
   wire cut_raw = CUT_IN.motor_low | CUT_IN.stop_latched | !CUT_IN.estop_24v_ok |
      CUT_IN.gateway_alarm | CUT_IN.actuator_comm_err;
   wire clean = !halt && !cut_raw && DRIVE_EN && MOVING;
   a_event_on_change: assert property ($changed(ERR_CODE) |-> ERR_EVENT)
      else $error("code changed without event");
   a_event_code_set: assert property (ERR_EVENT |-> ERR_CODE != mci_pkg::ERR_NONE)
      else $error("event with empty code");
   a_halt_no_drive: assert property (halt && $past(halt) |-> !DRIVE_EN)
      else $error("drive enabled during halt");
   a_halt_code: assert property ($rose(halt) |-> ##[1:3] ERR_CODE == mci_pkg::ERR_DRV_HALT)
      else $error("halt code missing");
   a_cut_code: assert property ($rose(cut_raw) && !halt |->
      ##[1:3] ERR_CODE == mci_pkg::ERR_CUTOFF)
      else $error("cutoff code missing");
   a_cut_no_drive: assert property (cut_raw |-> ##2 !DRIVE_EN)
      else $error("drive enabled in cutoff");
   a_servo_drop: assert property (clean && $fell(PLC_IN.servo_enable_input) |->
      ##[1:3] (ERR_CODE == mci_pkg::ERR_SERVO_OFF && !MOVING))
      else $error("servo drop not handled");
   a_dup_start: assert property (clean && PLC_IN.pause_hold_n && !MOVE_DONE &&
      $rose(PLC_IN.move_start_input) |-> ##[1:3] ERR_CODE == mci_pkg::ERR_DUP_START)
      else $error("duplicate start not flagged");
   a_move_servo: assert property ($rose(MOVING) |-> $past(PLC_IN.servo_enable_input))
      else $error("move began with servo off");
   a_write_gate: assert property (WRITE_APPLY |-> $past(PEND_IN.enable_mid) &&
      ($past(PEND_IN.write_req) || $past(PEND_IN.write_req, 2)))
      else $error("write applied without request");
   a_suction_gate: assert property ($rose(SUCTION_ON) |->
      $past(PEND_IN.suction_req) || $past(PEND_IN.suction_req, 2))
      else $error("suction without command");
   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data outside read slot");
   c_cutoff: cover property (ERR_EVENT && ERR_CODE == mci_pkg::ERR_CUTOFF);
   c_move: cover property ($rose(MOVING));
   c_write: cover property (WRITE_APPLY);
endmodule

// ===== bench/mci_plc_model.sv
`timescale 1ns/1ps
// =========================================================
// plc and operator side, registered so levels move after an edge
module mci_plc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire mci_pkg::mci_plc_type want,
   input wire logic grip,
   output mci_pkg::mci_plc_type plc,
   output logic enable_mid
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         plc <= 6'h08;
         enable_mid <= 1'b0;
      end else begin
         plc <= want;
         enable_mid <= grip;
      end
   end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk, rst_n, done, wr, rd, grip, pen, ev, ap;
   logic serv, drv, mov, wap, suc, irq, ee;
   logic [3:0] addr, pp;
   logic [31:0] wd, rdata, rv;
   logic [11:0] ecode;
   logic [5:0] cut;
   mci_pkg::mci_plc_type want, plc;
   int errors, num_checks;
   mci_plc_model u_plc (.clk(clk), .rst_n(rst_n), .want(want), .grip(grip), .plc(plc),
      .enable_mid(pen));
   mci_top DUT (.SYS_CLK(clk), .RESET_N(rst_n), .PLC_IN(plc), .CUT_IN(cut),
      .PEND_IN({pen, pp}), .MOVE_DONE(done), .REG_ADDR(addr), .REG_WDATA(wd),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SERVO_ON(serv), .DRIVE_EN(drv),
      .MOVING(mov), .WRITE_APPLY(wap), .SUCTION_ON(suc), .ERR_CODE(ecode),
      .ERR_EVENT(ee), .IRQ(irq));
   // =========================================================
   // helpers
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   // event pulses last one cycle, so every cycle is looked at
   task automatic watch;
      ev = 1'b0;
      ap = 1'b0;
      repeat (6) begin
         @(posedge clk);
         if (ee === 1'b1) ev = 1'b1;
         if (wap === 1'b1) ap = 1'b1;
      end
   endtask
   task automatic pbit(input int i, input logic v);
      @(posedge clk);
      want[i] <= v;
      watch;
   endtask
   task automatic cset(input logic [5:0] v);
      @(posedge clk);
      cut <= v;
      watch;
   endtask
   task automatic pcmd(input logic [3:0] m);
      @(posedge clk);
      pp <= m;
      @(posedge clk);
      pp <= 4'h0;
      watch;
   endtask
   task automatic exp_err(input logic [11:0] c);
      chk("err_event", ev, 32'h1);
      chk("err_code", ecode, c);
   endtask
   task automatic end_of_test;
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =========================================================
   // clock, watchdog, tests
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      tk(20000);
      errors++;
      end_of_test;
   end
   initial begin
      rst_n = 1'b0;
      want = 6'h08;
      cut = 6'h08;
      pp = 4'h0;
      grip = 1'b1;
      done = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wd = 32'h0;
      errors = 0;
      num_checks = 0;
      tk(3);
      rst_n <= 1'b1;
      rreg(mci_pkg::ADDR_ERR_CODE);
      chk("code_rst", rv, 32'h0);
      rreg(mci_pkg::ADDR_IRQ_MASK);
      chk("mask_rst", rv, 32'h0);
      rreg(4'hF);
      chk("unmapped", rv, 32'h0);
      pbit(4, 1'b1);
      exp_err(mci_pkg::ERR_SERVO_OFF);
      chk("moving", mov, 32'h0);
      pbit(4, 1'b0);
      pbit(5, 1'b1);
      chk("servo_on", serv, 32'h1);
      pbit(4, 1'b1);
      chk("moving", mov, 32'h1);
      pbit(4, 1'b0);
      pbit(4, 1'b1);
      exp_err(mci_pkg::ERR_DUP_START);
      pbit(4, 1'b0);
      pbit(2, 1'b1);
      exp_err(mci_pkg::ERR_HOME_MOVING);
      pbit(2, 1'b0);
      pbit(1, 1'b1);
      exp_err(mci_pkg::ERR_JOG_MOVING);
      pbit(1, 1'b0);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      tk(3);
      chk("move_done", mov, 32'h0);
      pbit(4, 1'b1);
      pbit(3, 1'b0);
      exp_err(mci_pkg::ERR_PAUSE);
      chk("moving", mov, 32'h0);
      pbit(3, 1'b1);
      pbit(4, 1'b0);
      pbit(4, 1'b1);
      pbit(5, 1'b0);
      exp_err(mci_pkg::ERR_SERVO_OFF);
      chk("moving", mov, 32'h0);
      chk("servo_off", serv, 32'h0);
      pbit(4, 1'b0);
      pbit(5, 1'b1);
      pbit(0, 1'b1);
      exp_err(mci_pkg::ERR_DRV_HALT);
      chk("drive", drv, 32'h0);
      pbit(0, 1'b0);
      cset(6'h09);
      exp_err(mci_pkg::ERR_SOFT_LIMIT);
      cset(6'h08);
      // one pass per cutoff cause, with time for the release filter
      for (int i = 0; i < 5; i++) begin
         cset(6'h08 ^ (6'h20 >> i));
         exp_err(mci_pkg::ERR_CUTOFF);
         chk("drive_cut", drv, 32'h0);
         chk("servo_cut", serv, 32'h0);
         cset(6'h08);
         tk(12);
      end
      grip <= 1'b0;
      tk(2);
      pcmd(4'h4);
      chk("no_grip_event", ev, 32'h0);
      chk("no_grip_suction", suc, 32'h0);
      grip <= 1'b1;
      tk(2);
      pcmd(4'h4);
      chk("suction", suc, 32'h1);
      pcmd(4'h4);
      exp_err(mci_pkg::ERR_SUCTION);
      pcmd(4'h2);
      chk("release", suc, 32'h0);
      tk(8);
      pcmd(4'h2);
      exp_err(mci_pkg::ERR_SUCTION);
      pcmd(4'h1);
      chk("pend_move", mov, 32'h1);
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      tk(3);
      chk("pend_done", mov, 32'h0);
      pcmd(4'h8);
      chk("teach_write", ap, 32'h1);
      wreg(mci_pkg::ADDR_CONTROL, 32'h1);
      pcmd(4'h8);
      exp_err(mci_pkg::ERR_WR_AUTO);
      chk("auto_apply", ap, 32'h0);
      wreg(mci_pkg::ADDR_CONTROL, 32'h2);
      pcmd(4'h8);
      exp_err(mci_pkg::ERR_WR_MON);
      chk("mon_apply", ap, 32'h0);
      wreg(mci_pkg::ADDR_CONTROL, 32'h3);
      rreg(mci_pkg::ADDR_STATE);
      chk("mode_kept", rv[1:0], 32'h2);
      wreg(mci_pkg::ADDR_CONTROL, 32'h0);
      rreg(mci_pkg::ADDR_IRQ_STATUS);
      chk("err_status", rv[0], 32'h1);
      chk("irq_status", rv[2:0], 32'h7);
      wreg(mci_pkg::ADDR_IRQ_MASK, 32'h1);
      tk(2);
      chk("irq_on", irq, 32'h1);
      wreg(mci_pkg::ADDR_IRQ_STATUS, 32'h7);
      tk(2);
      chk("irq_off", irq, 32'h0);
      rreg(mci_pkg::ADDR_IRQ_STATUS);
      chk("status_clr", rv[2:0], 32'h0);
      end_of_test;
   end
endmodule
bind mci_top mci_top_checker u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PLC_IN(PLC_IN),
   .CUT_IN(CUT_IN), .PEND_IN(PEND_IN), .MOVE_DONE(MOVE_DONE), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .DRIVE_EN(DRIVE_EN), .MOVING(MOVING), .WRITE_APPLY(WRITE_APPLY),
   .SUCTION_ON(SUCTION_ON), .ERR_CODE(ERR_CODE), .ERR_EVENT(ERR_EVENT));
